// [hdl/scss_top.sv]
// system clock source select with glitch-free switch and startup timer
`timescale 1ns/1ns
`default_nettype none
module scss_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire scss_pkg::scss_cfg_e config_oscillator_select,
  input wire scss_pkg::scss_ctrl_s oscillator_control_reg,
  input wire logic [scss_pkg::SCSS_NSRC-1:0] src_level,
  input wire logic clock_output_pin_request,
  output logic sys_clk_en,
  output logic [2:0] active_source,
  output logic switch_busy,
  output logic startup_done,
  output scss_pkg::scss_pad_s pad_ctrl
);
  // two-stage synchronisers on the source clocks
  logic [scss_pkg::SCSS_NSRC-1:0] sync1_reg, sync1_next;
  logic [scss_pkg::SCSS_NSRC-1:0] sync2_reg, sync2_next;
  logic [scss_pkg::SCSS_NSRC-1:0] prev_reg, prev_next;
  logic [scss_pkg::SCSS_NSRC-1:0] rise;
  logic [2:0] cur_reg, cur_next;
  logic [2:0] pend_reg, pend_next;
  logic busy_reg, busy_next;
  logic [10:0] ost_reg, ost_next;
  logic ost_done_reg, ost_done_next;
  logic en_reg, en_next;
  scss_pkg::scss_pad_s pad_reg, pad_next;
  logic [2:0] want;
  logic cfg_ext;
  logic cfg_ec;

  // external source uses the configuration encodings
  function automatic logic is_ec(input scss_pkg::scss_cfg_e c);
    is_ec = (c == scss_pkg::SCSS_CFG_EC_LOW) || (c == scss_pkg::SCSS_CFG_EC_MED) ||
            (c == scss_pkg::SCSS_CFG_EC_HIGH);
  endfunction

  function automatic logic [2:0] int_src(input scss_pkg::scss_int_e f);
    unique case (f)
      scss_pkg::SCSS_INT_FAST: int_src = scss_pkg::SCSS_SRC_FAST;
      scss_pkg::SCSS_INT_MID: int_src = scss_pkg::SCSS_SRC_MID;
      scss_pkg::SCSS_INT_SLOW: int_src = scss_pkg::SCSS_SRC_SLOW;
      scss_pkg::SCSS_INT_RSVD: int_src = scss_pkg::SCSS_SRC_SLOW;
    endcase
  endfunction

  assign cfg_ec = is_ec(config_oscillator_select);
  assign cfg_ext = config_oscillator_select != scss_pkg::SCSS_CFG_INTOSC;
  assign rise = sync2_reg & ~prev_reg;

  // source the select field asks for
  always_comb begin
    unique case (oscillator_control_reg.system_clock_select)
      scss_pkg::SCSS_SEL_CONFIG: want = cfg_ext ? scss_pkg::SCSS_SRC_EXT :
                                        int_src(oscillator_control_reg.int_freq_select);
      scss_pkg::SCSS_SEL_SECOND: want = scss_pkg::SCSS_SRC_SEC;
      scss_pkg::SCSS_SEL_INT_A,
      scss_pkg::SCSS_SEL_INT_B: want = int_src(oscillator_control_reg.int_freq_select);
    endcase
  end

  always_comb begin
    sync1_next = src_level;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    cur_next = cur_reg;
    pend_next = pend_reg;
    busy_next = busy_reg;
    ost_next = ost_reg;
    ost_done_next = ost_done_reg;
    en_next = 1'b0;
    if (!busy_reg && want != cur_reg) begin
      // wait for a new source edge before handing over
      busy_next = 1'b1;
      pend_next = want;
      ost_next = '0;
      ost_done_next = (want != scss_pkg::SCSS_SRC_EXT) || cfg_ec;
    end else if (busy_reg) begin
      if (rise[pend_reg]) begin
        if (ost_done_reg) begin
          cur_next = pend_reg;
          busy_next = 1'b0;
          en_next = 1'b1;
        end else if (ost_reg == scss_pkg::SCSS_OST_LAST - 11'h1) begin
          ost_done_next = 1'b1;
        end else begin
          ost_next = ost_reg + 11'h1;
        end
      end
    end else begin
      // one enable per edge of the live source; none while it stands still
      en_next = rise[cur_reg] && ost_done_reg;
    end
    pad_next.amp_gain = scss_pkg::SCSS_GAIN_OFF;
    pad_next.ext_power = scss_pkg::SCSS_PWR_NONE;
    unique case (config_oscillator_select)
      scss_pkg::SCSS_CFG_LP_XTAL: pad_next.amp_gain = scss_pkg::SCSS_GAIN_LOW;
      scss_pkg::SCSS_CFG_XT_XTAL: pad_next.amp_gain = scss_pkg::SCSS_GAIN_MID;
      scss_pkg::SCSS_CFG_HS_XTAL: pad_next.amp_gain = scss_pkg::SCSS_GAIN_HIGH;
      scss_pkg::SCSS_CFG_EC_LOW: pad_next.ext_power = scss_pkg::SCSS_PWR_LOW;
      scss_pkg::SCSS_CFG_EC_MED: pad_next.ext_power = scss_pkg::SCSS_PWR_MED;
      scss_pkg::SCSS_CFG_EC_HIGH: pad_next.ext_power = scss_pkg::SCSS_PWR_HIGH;
      scss_pkg::SCSS_CFG_INTOSC,
      scss_pkg::SCSS_CFG_SPARE: pad_next.amp_gain = scss_pkg::SCSS_GAIN_OFF;
    endcase
    pad_next.crystal_out_released = cfg_ec || !cfg_ext;
    pad_next.clock_output_en = pad_next.crystal_out_released && clock_output_pin_request;
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
      cur_reg <= scss_pkg::SCSS_SRC_SLOW;
      pend_reg <= scss_pkg::SCSS_SRC_SLOW;
      busy_reg <= 1'b0;
      ost_reg <= '0;
      ost_done_reg <= 1'b1;
      en_reg <= 1'b0;
      pad_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      cur_reg <= cur_next;
      pend_reg <= pend_next;
      busy_reg <= busy_next;
      ost_reg <= ost_next;
      ost_done_reg <= ost_done_next;
      en_reg <= en_next;
      pad_reg <= pad_next;
    end
  end

  assign sys_clk_en = en_reg;
  assign active_source = cur_reg;
  assign switch_busy = busy_reg;
  assign startup_done = ost_done_reg;
  assign pad_ctrl = pad_reg;

  chk_no_enable_busy: assert property (@(posedge core_clk) disable iff (!nrst)
    busy_reg |=> !en_reg || !busy_reg) else $error("enable during switch");
  chk_ec_no_ost: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy_reg && want == scss_pkg::SCSS_SRC_EXT && cur_reg != want && cfg_ec) |=> ost_done_reg)
    else $error("startup timer not bypassed");
  chk_enable_edge: assert property (@(posedge core_clk) disable iff (!nrst)
    en_reg |-> $past(rise[cur_reg]) || $past(busy_reg)) else $error("enable without edge");
  chk_gain_map: assert property (@(posedge core_clk) disable iff (!nrst)
    (config_oscillator_select == scss_pkg::SCSS_CFG_HS_XTAL) |=> pad_reg.amp_gain == scss_pkg::SCSS_GAIN_HIGH)
    else $error("gain wrong");
  chk_power_map: assert property (@(posedge core_clk) disable iff (!nrst)
    (config_oscillator_select == scss_pkg::SCSS_CFG_EC_LOW) |=> pad_reg.ext_power == scss_pkg::SCSS_PWR_LOW)
    else $error("power range wrong");
  chk_pin_release: assert property (@(posedge core_clk) disable iff (!nrst)
    pad_reg.clock_output_en |-> pad_reg.crystal_out_released) else $error("clock_output_pin on crystal pin");
  chk_switch_target: assert property (@(posedge core_clk) disable iff (!nrst)
    (busy_reg && !busy_next) |=> cur_reg == $past(pend_reg)) else $error("wrong source");
  chk_second_select: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy_reg && oscillator_control_reg.system_clock_select == scss_pkg::SCSS_SEL_SECOND
     && cur_reg != scss_pkg::SCSS_SRC_SEC) |=> pend_reg == scss_pkg::SCSS_SRC_SEC)
    else $error("secondary not chosen");

  // a switch request seen while idle
  sequence seq_idle_change;
    !busy_reg && want != cur_reg;
  endsequence

  // a counted source edge while the startup timer still runs
  sequence seq_ost_edge;
    busy_reg && !ost_done_reg && rise[pend_reg];
  endsequence

  // a pending switch with no new source edge yet
  sequence seq_pend_wait;
    busy_reg && !rise[pend_reg];
  endsequence

  chk_switch_start: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_idle_change |=> busy_reg && pend_reg == $past(want))
    else $error("switch not started");
  chk_ost_count: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_ost_edge |=> ost_done_reg || ost_reg == $past(ost_reg) + 11'h1)
    else $error("startup timer miscounted");
  chk_busy_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    seq_pend_wait |=> busy_reg && cur_reg == $past(cur_reg))
    else $error("source changed early");
  chk_stall_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy_reg && !rise[cur_reg]) |=> !en_reg)
    else $error("enable while source still");
  chk_int_route: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy_reg && oscillator_control_reg.system_clock_select == scss_pkg::SCSS_SEL_INT_A
     && oscillator_control_reg.int_freq_select == scss_pkg::SCSS_INT_FAST
     && cur_reg != scss_pkg::SCSS_SRC_FAST) |=> pend_reg == scss_pkg::SCSS_SRC_FAST)
    else $error("fast internal not chosen");
  chk_config_default: assert property (@(posedge core_clk) disable iff (!nrst)
    (!busy_reg && oscillator_control_reg.system_clock_select == scss_pkg::SCSS_SEL_CONFIG
     && cfg_ext && cur_reg != scss_pkg::SCSS_SRC_EXT) |=> pend_reg == scss_pkg::SCSS_SRC_EXT)
    else $error("configured source not chosen");
  chk_gain_low: assert property (@(posedge core_clk) disable iff (!nrst)
    (config_oscillator_select == scss_pkg::SCSS_CFG_LP_XTAL) |=> pad_reg.amp_gain == scss_pkg::SCSS_GAIN_LOW)
    else $error("low gain wrong");
  chk_gain_mid: assert property (@(posedge core_clk) disable iff (!nrst)
    (config_oscillator_select == scss_pkg::SCSS_CFG_XT_XTAL) |=> pad_reg.amp_gain == scss_pkg::SCSS_GAIN_MID)
    else $error("medium gain wrong");
  chk_power_med: assert property (@(posedge core_clk) disable iff (!nrst)
    (config_oscillator_select == scss_pkg::SCSS_CFG_EC_MED) |=> pad_reg.ext_power == scss_pkg::SCSS_PWR_MED)
    else $error("medium power wrong");
  chk_power_high: assert property (@(posedge core_clk) disable iff (!nrst)
    (config_oscillator_select == scss_pkg::SCSS_CFG_EC_HIGH) |=> pad_reg.ext_power == scss_pkg::SCSS_PWR_HIGH)
    else $error("high power wrong");
  chk_release_ec: assert property (@(posedge core_clk) disable iff (!nrst)
    cfg_ec |=> pad_reg.crystal_out_released)
    else $error("crystal output not released");
endmodule // scss_top
`default_nettype wire

// [pkg/scss_pkg.sv]
// package for the system clock source select block
`default_nettype none
package scss_pkg;
  // configuration oscillator select encodings
  typedef enum logic [2:0] {
    SCSS_CFG_LP_XTAL = 3'h0,
    SCSS_CFG_XT_XTAL = 3'h1,
    SCSS_CFG_HS_XTAL = 3'h2,
    SCSS_CFG_EC_LOW  = 3'h3,
    SCSS_CFG_EC_MED  = 3'h4,
    SCSS_CFG_EC_HIGH = 3'h5,
    SCSS_CFG_INTOSC  = 3'h6,
    SCSS_CFG_SPARE   = 3'h7
  } scss_cfg_e;
  // system clock select field
  typedef enum logic [1:0] {
    SCSS_SEL_CONFIG = 2'h0,
    SCSS_SEL_SECOND = 2'h1,
    SCSS_SEL_INT_A  = 2'h2,
    SCSS_SEL_INT_B  = 2'h3
  } scss_sel_e;
  // internal oscillator frequency select
  typedef enum logic [1:0] {
    SCSS_INT_FAST = 2'h0,
    SCSS_INT_MID  = 2'h1,
    SCSS_INT_SLOW = 2'h2,
    SCSS_INT_RSVD = 2'h3
  } scss_int_e;
  // mux source indices
  localparam logic [2:0] SCSS_SRC_EXT = 3'h0;
  localparam logic [2:0] SCSS_SRC_SEC = 3'h1;
  localparam logic [2:0] SCSS_SRC_FAST = 3'h2;
  localparam logic [2:0] SCSS_SRC_MID = 3'h3;
  localparam logic [2:0] SCSS_SRC_SLOW = 3'h4;
  localparam int SCSS_NSRC = 5;
  // amplifier gain codes
  localparam logic [1:0] SCSS_GAIN_OFF = 2'h0;
  localparam logic [1:0] SCSS_GAIN_LOW = 2'h1;
  localparam logic [1:0] SCSS_GAIN_MID = 2'h2;
  localparam logic [1:0] SCSS_GAIN_HIGH = 2'h3;
  // external clock power ranges
  localparam logic [1:0] SCSS_PWR_NONE = 2'h0;
  localparam logic [1:0] SCSS_PWR_LOW = 2'h1;
  localparam logic [1:0] SCSS_PWR_MED = 2'h2;
  localparam logic [1:0] SCSS_PWR_HIGH = 2'h3;
  // startup timer length, in source edges
  localparam int SCSS_OST_EDGES = 1024;
  localparam logic [10:0] SCSS_OST_LAST = 11'(SCSS_OST_EDGES);
  // oscillator control fields
  typedef struct packed {
    scss_sel_e system_clock_select;
    scss_int_e int_freq_select;
  } scss_ctrl_s;
  // pad control outputs
  typedef struct packed {
    logic [1:0] amp_gain;
    logic [1:0] ext_power;
    logic crystal_out_released;
    logic clock_output_en;
  } scss_pad_s;
endpackage
`default_nettype wire

// [testbench/scss_osc_model.sv]
// source clock model: external, secondary and internal oscillators
`timescale 1ns/1ns
`default_nettype none
module scss_osc_model (
  input wire logic ext_run,
  output logic [4:0] src_level
);
  initial begin
    src_level = 5'h00;
  end
  // external clock halts while ext_run is low
  always #20 if (ext_run) src_level[0] = ~src_level[0];
  always #45 src_level[1] = ~src_level[1];
  always #15 src_level[2] = ~src_level[2];
  always #35 src_level[3] = ~src_level[3];
  always #65 src_level[4] = ~src_level[4];
endmodule // scss_osc_model
`default_nettype wire

// [testbench/system_clock_source_select_tb.sv]
// self-checking bench for the clock source select block
`timescale 1ns/1ns
`default_nettype none
module system_clock_source_select_tb;
  logic core_clk, nrst, ext_run, clock_output_pin_request, sys_clk_en, switch_busy, startup_done;
  scss_pkg::scss_cfg_e cfg;
  scss_pkg::scss_ctrl_s ctrl;
  logic [4:0] src_level;
  logic [2:0] active_source;
  scss_pkg::scss_pad_s pad_ctrl;
  int fails, check_count, cycles, n, c;
  scss_top scss_top_i (.core_clk(core_clk), .nrst(nrst), .config_oscillator_select(cfg),
    .oscillator_control_reg(ctrl), .src_level(src_level), .clock_output_pin_request(clock_output_pin_request),
    .sys_clk_en(sys_clk_en), .active_source(active_source), .switch_busy(switch_busy),
    .startup_done(startup_done), .pad_ctrl(pad_ctrl));
  scss_osc_model scss_osc_model_i (.ext_run(ext_run), .src_level(src_level));
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task settle;
    n = 0;
    repeat (3) @(posedge core_clk);
    #1;
    while (switch_busy !== 1'b0 && n < 6000) begin
      @(posedge core_clk);
      #1;
      n++;
    end
  endtask
  task count_en;
    c = 0;
    repeat (100) begin
      @(posedge core_clk);
      #1;
      if (sys_clk_en === 1'b1) c++;
    end
  endtask
  task do_reset(input int code);
    @(posedge core_clk);
    nrst <= 1'b0;
    cfg <= scss_pkg::scss_cfg_e'(3'(code));
    ctrl <= '{scss_pkg::SCSS_SEL_CONFIG, scss_pkg::SCSS_INT_FAST};
    repeat (8) @(posedge core_clk);
    #1;
    chk(16'(active_source), 16'h0004);
    chk(16'(pad_ctrl), 16'h0000);
    @(posedge core_clk);
    nrst <= 1'b1;
    settle;
  endtask
  task ec_modes;
    for (int i = 0; i < 3; i++) begin
      do_reset(3 + i);
      chk(16'(active_source), 16'(scss_pkg::SCSS_SRC_EXT));
      chk(16'(pad_ctrl.ext_power), 16'(scss_pkg::SCSS_PWR_LOW + 2'(i)));
      chk(16'(pad_ctrl.crystal_out_released), 16'h0001);
      chk(16'({startup_done, n < 20}), 16'h0003);
    end
    @(posedge core_clk);
    clock_output_pin_request <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(16'(pad_ctrl.clock_output_en), 16'h0001);
  endtask
  task xtal_modes;
    for (int i = 0; i < 3; i++) begin
      do_reset(i);
      chk(16'(pad_ctrl.amp_gain), 16'(scss_pkg::SCSS_GAIN_LOW + 2'(i)));
      chk(16'(active_source), 16'(scss_pkg::SCSS_SRC_EXT));
      chk(16'(n >= scss_pkg::SCSS_OST_EDGES * 3), 16'h0001);
    end
  endtask
  task int_select;
    do_reset(5);
    for (int f = 0; f < 3; f++) begin
      @(posedge core_clk);
      ctrl <= '{scss_pkg::SCSS_SEL_INT_A, scss_pkg::scss_int_e'(2'(f))};
      settle;
      chk(16'(active_source), 16'(scss_pkg::SCSS_SRC_FAST + 3'(f)));
    end
    @(posedge core_clk);
    ctrl <= '{scss_pkg::SCSS_SEL_INT_B, scss_pkg::SCSS_INT_FAST};
    @(posedge core_clk);
    ctrl <= '{scss_pkg::SCSS_SEL_SECOND, scss_pkg::SCSS_INT_FAST};
    settle;
    settle;
    chk(16'(active_source), 16'(scss_pkg::SCSS_SRC_SEC));
    @(posedge core_clk);
    ctrl <= '{scss_pkg::SCSS_SEL_CONFIG, scss_pkg::SCSS_INT_FAST};
    settle;
    chk(16'(active_source), 16'(scss_pkg::SCSS_SRC_EXT));
  endtask
  task ext_stop;
    count_en;
    chk(16'(c >= 24 && c <= 26), 16'h0001);
    ext_run = 1'b0;
    repeat (10) @(posedge core_clk);
    count_en;
    chk(16'(c), 16'h0000);
    chk(16'(active_source), 16'(scss_pkg::SCSS_SRC_EXT));
    ext_run = 1'b1;
    repeat (10) @(posedge core_clk);
    count_en;
    chk(16'(c >= 24 && c <= 26), 16'h0001);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 40000) begin
      fails++;
      end_sim;
    end
  end
  initial begin
    nrst = 1'b0;
    ext_run = 1'b1;
    clock_output_pin_request = 1'b0;
    cfg = scss_pkg::SCSS_CFG_EC_HIGH;
    ctrl = '{scss_pkg::SCSS_SEL_CONFIG, scss_pkg::SCSS_INT_FAST};
    ec_modes;
    xtal_modes;
    int_select;
    ext_stop;
    end_sim;
  end
endmodule // system_clock_source_select_tb
`default_nettype wire
